// [common/uotg_defines.svh]
`ifndef UOTG_DEFINES_SVH
`define UOTG_DEFINES_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define UOTG_OFF_STAT 8'h00
`define UOTG_OFF_CTRL 8'h04
`define UOTG_OFF_PWRC 8'h08
`define UOTG_OFF_IRQF 8'h0C
`define UOTG_OFF_IRQM 8'h10
`define UOTG_RESP_OKAY 2'h0
`define UOTG_RESP_SLVERR 2'h2
`define UOTG_REG_RST 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define UOTG_B_ID 7
`define UOTG_B_LSTB 5
`define UOTG_B_ACT 4
`define UOTG_B_SESS 3
`define UOTG_B_BEND 2
`define UOTG_B_AVLD 0
`define UOTG_B_SWRES 2
`define UOTG_B_PEND 7
`define UOTG_B_GUARD 4
`define UOTG_B_BUSY 3
`define UOTG_B_SUSP 1
`define UOTG_B_EN 0
`define UOTG_B_RES_HI 7
`define UOTG_B_RES_LO 4
`define UOTG_B_VBON 3
`define UOTG_B_CHG 1
`define UOTG_B_DIS 0
`define UOTG_PWRC_WMASK 8'h13
`define UOTG_STAT_MASK 8'hAD
`define UOTG_FLAG_MASK 8'hBD
// ----------------------------------------
// timing
// ----------------------------------------
`define UOTG_CLK_MHZ 125
`define UOTG_LINE_STABLE_US 1000
`define UOTG_DRAIN_CYCLES 5'h10
`endif

// [common/uotg_pkg.sv]
package uotg_pkg;
    typedef struct packed {
        logic cable_identity;
        logic session_valid;
        logic b_session_end;
        logic a_vbus_valid;
        logic activity;
    } uotg_pins_t;

    typedef struct packed {
        logic dplus_pullup_en;
        logic dminus_pullup_en;
        logic dplus_pulldown_en;
        logic dminus_pulldown_en;
    } uotg_res_t;

    typedef struct packed {
        uotg_res_t res;
        logic vbus_power_on;
        logic vbus_charge_en;
        logic vbus_discharge_en;
    } uotg_line_ctl_t;

    typedef struct packed {
        logic aw_held;
        logic w_held;
        logic [7:0] waddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } uotg_axi_t;
endpackage : uotg_pkg

// [hdl/uotg_power_ctrl.sv]
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "uotg_defines.svh"
module uotg_power_ctrl #(
    parameter int LINE_CYCLES = `UOTG_LINE_STABLE_US * `UOTG_CLK_MHZ
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire uotg_pkg::uotg_pins_t pins_in,
    input wire logic single_ended_zero_flag,
    input wire logic j_state_flag,
    input wire uotg_pkg::uotg_res_t hw_res,
    output uotg_pkg::uotg_line_ctl_t line_ctl,
    output logic usb_clk_en,
    output logic xcvr_low_power,
    output logic sleep_block,
    output logic irq
);
    typedef struct packed {
        uotg_pkg::uotg_axi_t axi;
        uotg_pkg::uotg_pins_t sync1;
        uotg_pkg::uotg_pins_t sync2;
        uotg_pkg::uotg_pins_t prev;
        logic [1:0] line_prev;
        logic [16:0] line_cnt;
        logic line_stable;
        logic [7:0] ctrl;
        logic [7:0] pwrc;
        logic [7:0] flags;
        logic [7:0] mask;
        logic pending;
        logic [4:0] drain;
        uotg_pkg::uotg_line_ctl_t out;
        logic clk_en;
        logic low_power;
        logic sleep_block;
        logic irq;
    } uotg_state_t;

    localparam logic [16:0] LINE_LAST = 17'(LINE_CYCLES - 1);

    uotg_state_t s;
    uotg_state_t n;
    logic [1:0] line_now;
    logic [7:0] stat_rd;
    logic [7:0] pwrc_rd;
    logic [7:0] rd_byte;
    logic [7:0] set_ev;
    logic [7:0] clr_ev;
    logic act_edge;
    logic busy;
    logic enable;
    logic suspend;
    logic wr_fire;
    logic [7:0] wb;
    logic rd_stat;

    // ----------------------------------------
    // read views
    // ----------------------------------------
    assign enable = s.pwrc[`UOTG_B_EN];
    assign suspend = s.pwrc[`UOTG_B_SUSP];
    // drain keeps busy up after disable so the analog side can settle
    assign busy = enable | (s.drain != 5'h00);
    assign line_now = {single_ended_zero_flag, j_state_flag};

    always_comb begin
        stat_rd = 8'h00;
        stat_rd[`UOTG_B_ID] = s.sync2.cable_identity;
        stat_rd[`UOTG_B_LSTB] = s.line_stable;
        stat_rd[`UOTG_B_SESS] = s.sync2.session_valid;
        stat_rd[`UOTG_B_BEND] = s.sync2.b_session_end;
        stat_rd[`UOTG_B_AVLD] = s.sync2.a_vbus_valid;
        pwrc_rd = s.pwrc & `UOTG_PWRC_WMASK;
        pwrc_rd[`UOTG_B_PEND] = s.pending;
        pwrc_rd[`UOTG_B_BUSY] = busy;
    end

    always_comb begin
        rd_byte = 8'h00;
        if (s_axi_araddr == `UOTG_OFF_STAT) begin
            rd_byte = stat_rd;
        end else if (s_axi_araddr == `UOTG_OFF_CTRL) begin
            rd_byte = s.ctrl;
        end else if (s_axi_araddr == `UOTG_OFF_PWRC) begin
            rd_byte = pwrc_rd;
        end else if (s_axi_araddr == `UOTG_OFF_IRQF) begin
            rd_byte = s.flags;
        end else if (s_axi_araddr == `UOTG_OFF_IRQM) begin
            rd_byte = s.mask;
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    assign wr_fire = s.axi.aw_held & s.axi.w_held & ~s.axi.bvalid;
    assign wb = s.axi.wdata;
    assign act_edge = s.sync2.activity & ~s.prev.activity;

    always_comb begin
        n = s;
        set_ev = 8'h00;
        clr_ev = 8'h00;
        // first stage feeds only the second
        n.sync1 = pins_in;
        n.sync2 = s.sync1;
        n.prev = s.sync2;
        // line stability timer
        n.line_prev = line_now;
        if (line_now != s.line_prev) begin
            n.line_cnt = 17'h00000;
            n.line_stable = 1'b0;
        end else if (s.line_cnt >= LINE_LAST) begin
            n.line_stable = 1'b1;
        end else begin
            n.line_cnt = s.line_cnt + 17'h00001;
        end
        // change events, only while enabled
        if (enable) begin
            set_ev[`UOTG_B_ID] = s.sync2.cable_identity ^ s.prev.cable_identity;
            set_ev[`UOTG_B_LSTB] = n.line_stable & ~s.line_stable;
            set_ev[`UOTG_B_SESS] = s.sync2.session_valid ^ s.prev.session_valid;
            set_ev[`UOTG_B_BEND] = s.sync2.b_session_end ^ s.prev.b_session_end;
            set_ev[`UOTG_B_AVLD] = s.sync2.a_vbus_valid ^ s.prev.a_vbus_valid;
            // in suspend the flag waits until the clock is back
            if (suspend) begin
                if (act_edge) begin
                    n.pending = 1'b1;
                end
            end else begin
                set_ev[`UOTG_B_ACT] = act_edge | s.pending;
                n.pending = 1'b0;
            end
        end else begin
            n.pending = 1'b0;
        end
        // register writes, byte lane 0 only
        if (wr_fire) begin
            n.axi.aw_held = 1'b0;
            n.axi.w_held = 1'b0;
            n.axi.bvalid = 1'b1;
            n.axi.bresp = `UOTG_RESP_OKAY;
            if (s.axi.waddr == `UOTG_OFF_CTRL) begin
                if (s.axi.wstrb0) begin
                    n.ctrl = wb;
                end
            end else if (s.axi.waddr == `UOTG_OFF_PWRC) begin
                if (s.axi.wstrb0) begin
                    n.pwrc = wb & `UOTG_PWRC_WMASK;
                end
            end else if (s.axi.waddr == `UOTG_OFF_IRQF) begin
                if (s.axi.wstrb0) begin
                    clr_ev = wb;
                end
            end else if (s.axi.waddr == `UOTG_OFF_IRQM) begin
                if (s.axi.wstrb0) begin
                    n.mask = wb & `UOTG_FLAG_MASK;
                end
            end else if (s.axi.waddr != `UOTG_OFF_STAT) begin
                n.axi.bresp = `UOTG_RESP_SLVERR;
            end
        end
        // set wins over a clear in the same cycle
        n.flags = ((s.flags & ~clr_ev) | set_ev) & `UOTG_FLAG_MASK;
        // busy drain after disable
        if (enable & ~n.pwrc[`UOTG_B_EN]) begin
            n.drain = `UOTG_DRAIN_CYCLES;
        end else if (s.drain != 5'h00) begin
            n.drain = s.drain - 5'h01;
        end
        // line and supply drive
        n.out = '0;
        if (enable) begin
            if (s.ctrl[`UOTG_B_SWRES]) begin
                n.out.res = uotg_pkg::uotg_res_t'(s.ctrl[`UOTG_B_RES_HI:`UOTG_B_RES_LO]);
            end else begin
                n.out.res = hw_res;
            end
            n.out.vbus_power_on = s.ctrl[`UOTG_B_VBON];
            n.out.vbus_charge_en = s.ctrl[`UOTG_B_CHG];
            n.out.vbus_discharge_en = s.ctrl[`UOTG_B_DIS];
        end
        n.clk_en = enable & ~suspend;
        n.low_power = ~enable | suspend;
        n.sleep_block = s.pwrc[`UOTG_B_GUARD] & (s.sync2.activity | s.pending);
        n.irq = |(n.flags & n.mask);
        // write address and data, either order
        if (s_axi_awvalid & s_axi_awready) begin
            n.axi.aw_held = 1'b1;
            n.axi.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            n.axi.w_held = 1'b1;
            n.axi.wdata = s_axi_wdata[7:0];
            n.axi.wstrb0 = s_axi_wstrb[0];
        end
        if (s.axi.bvalid & s_axi_bready) begin
            n.axi.bvalid = 1'b0;
        end
        // read channel
        if (s_axi_arvalid & s_axi_arready) begin
            n.axi.rvalid = 1'b1;
            n.axi.rdata = {24'h000000, rd_byte};
            if (s_axi_araddr > `UOTG_OFF_IRQM || s_axi_araddr[1:0] != 2'h0) begin
                n.axi.rresp = `UOTG_RESP_SLVERR;
            end else begin
                n.axi.rresp = `UOTG_RESP_OKAY;
            end
        end else if (s.axi.rvalid & s_axi_rready) begin
            n.axi.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign s_axi_awready = ~s.axi.aw_held & ~s.axi.bvalid;
    assign s_axi_wready = ~s.axi.w_held & ~s.axi.bvalid;
    assign s_axi_bvalid = s.axi.bvalid;
    assign s_axi_bresp = s.axi.bresp;
    assign s_axi_arready = ~s.axi.rvalid;
    assign s_axi_rvalid = s.axi.rvalid;
    assign s_axi_rdata = s.axi.rdata;
    assign s_axi_rresp = s.axi.rresp;
    assign line_ctl = s.out;
    assign usb_clk_en = s.clk_en;
    assign xcvr_low_power = s.low_power;
    assign sleep_block = s.sleep_block;
    assign irq = s.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    property p_sw_res;
        enable && s.ctrl[`UOTG_B_SWRES] |=> line_ctl.res == $past(s.ctrl[7:4]);
    endproperty
    a_sw_res: assert property (p_sw_res) else $error("sw resistor drive wrong");

    property p_hw_res;
        enable && !s.ctrl[`UOTG_B_SWRES] |=> line_ctl.res == $past(hw_res);
    endproperty
    a_hw_res: assert property (p_hw_res) else $error("hw resistor drive wrong");

    property p_vbus;
        enable |=> line_ctl.vbus_power_on == $past(s.ctrl[3])
            && line_ctl.vbus_charge_en == $past(s.ctrl[1])
            && line_ctl.vbus_discharge_en == $past(s.ctrl[0]);
    endproperty
    a_vbus: assert property (p_vbus) else $error("vbus switch wrong");

    property p_off;
        !enable |=> line_ctl == '0 && xcvr_low_power && !usb_clk_en;
    endproperty
    a_off: assert property (p_off) else $error("outputs active while off");

    property p_susp;
        suspend |=> !usb_clk_en && xcvr_low_power;
    endproperty
    a_susp: assert property (p_susp) else $error("clock not gated");

    property p_line;
        line_now != s.line_prev |=> !s.line_stable [*2];
    endproperty
    a_line: assert property (p_line) else $error("line stable too early");

    property p_id_flag;
        enable && (s.sync2.cable_identity != s.prev.cable_identity) |=> s.flags[`UOTG_B_ID];
    endproperty
    a_id_flag: assert property (p_id_flag) else $error("identity flag lost");

    property p_drain;
        $fell(enable) |-> busy [*8];
    endproperty
    a_drain: assert property (p_drain) else $error("busy dropped early");

    property p_guard;
        s.pwrc[`UOTG_B_GUARD] && s.pending |=> sleep_block;
    endproperty
    a_guard: assert property (p_guard) else $error("sleep not blocked");

    property p_rd_zero;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("upper bits set");

    // ----------------------------------------
    // read-back and sticky checks
    // ----------------------------------------
    // status must show the synchronised levels, never the raw pins
    assign rd_stat = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `UOTG_OFF_STAT);

    property p_rd_id;
        rd_stat |=> s_axi_rdata[`UOTG_B_ID] == $past(s.sync2.cable_identity);
    endproperty
    a_rd_id: assert property (p_rd_id) else $error("identity bit wrong");

    property p_rd_lstb;
        rd_stat |=> s_axi_rdata[`UOTG_B_LSTB] == $past(s.line_stable);
    endproperty
    a_rd_lstb: assert property (p_rd_lstb) else $error("line stable bit wrong");

    property p_rd_sess;
        rd_stat |=> s_axi_rdata[`UOTG_B_SESS] == $past(s.sync2.session_valid);
    endproperty
    a_rd_sess: assert property (p_rd_sess) else $error("session bit wrong");

    property p_rd_bend;
        rd_stat |=> s_axi_rdata[`UOTG_B_BEND] == $past(s.sync2.b_session_end);
    endproperty
    a_rd_bend: assert property (p_rd_bend) else $error("session end bit wrong");

    property p_rd_avld;
        rd_stat |=> s_axi_rdata[`UOTG_B_AVLD] == $past(s.sync2.a_vbus_valid);
    endproperty
    a_rd_avld: assert property (p_rd_avld) else $error("a vbus bit wrong");

    property p_rd_gaps;
        rd_stat |=> (s_axi_rdata[7:0] & ~`UOTG_STAT_MASK) == 8'h00;
    endproperty
    a_rd_gaps: assert property (p_rd_gaps) else $error("status gap bit set");

    property p_pwrc_ro;
        (s.pwrc & ~`UOTG_PWRC_WMASK) == 8'h00;
    endproperty
    a_pwrc_ro: assert property (p_pwrc_ro) else $error("read-only power bit stored");

    property p_ro_write;
        wr_fire && s.axi.waddr == `UOTG_OFF_STAT |=> $stable(s.ctrl) && $stable(s.pwrc)
            && $stable(s.mask);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("status write changed state");

    property p_pend;
        enable && suspend && act_edge |=> s.pending;
    endproperty
    a_pend: assert property (p_pend) else $error("activity not held pending");

    property p_pend_clr;
        !(enable && suspend) |=> !s.pending;
    endproperty
    a_pend_clr: assert property (p_pend_clr) else $error("pending outside suspend");

    property p_act_flag;
        enable && !suspend && s.pending |=> s.flags[`UOTG_B_ACT];
    endproperty
    a_act_flag: assert property (p_act_flag) else $error("pending activity lost");

    property p_sleep_off;
        !s.pwrc[`UOTG_B_GUARD] |=> !sleep_block;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep blocked unguarded");

    property p_flag_hold;
        s.flags[`UOTG_B_ID] && !(wr_fire && s.axi.waddr == `UOTG_OFF_IRQF
            && s.axi.wstrb0 && wb[`UOTG_B_ID]) |=> s.flags[`UOTG_B_ID];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without write");

    c_stable: cover property (!s.line_stable ##1 s.line_stable);
    c_pending: cover property (s.pending ##1 !suspend);
    c_irq: cover property (!irq ##1 irq);
    c_drain: cover property (busy ##1 !busy);
endmodule : uotg_power_ctrl

// [verif/uotg_cable_model.sv]
`timescale 1ns/1ns
module uotg_cable_model (
    input wire logic cable_a,
    input wire logic ext_vbus,
    input wire logic bus_act,
    input wire uotg_pkg::uotg_line_ctl_t line_ctl,
    output uotg_pkg::uotg_pins_t pins
);
    logic vbus;
    // ----------------------------------------
    // cable and vbus levels
    // ----------------------------------------
    // discharge beats our own supply, an external supply wins over both
    assign vbus = ext_vbus | (line_ctl.vbus_power_on & ~line_ctl.vbus_discharge_en);
    // one driver for the whole struct: identity, session, b end, a valid, activity
    assign pins = {~cable_a, vbus, ~vbus & ~cable_a, vbus & cable_a, bus_act};
endmodule : uotg_cable_model

// [verif/tb_top.sv]
`timescale 1ns/1ns
`include "uotg_defines.svh"
module tb_top;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rdv, v;
    logic single_ended_zero_flag = 1'b0, j_state_flag = 1'b0;
    logic cable_a = 1'b0, ext_vbus = 1'b0, bus_act = 1'b0;
    logic usb_clk_en, xcvr_low_power, sleep_block, irq;
    uotg_pkg::uotg_pins_t pins_in;
    uotg_pkg::uotg_res_t hw_res = 4'h0;
    uotg_pkg::uotg_line_ctl_t line_ctl;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h00018196;

    uotg_power_ctrl #(.LINE_CYCLES(20)) uotg_power_ctrl_inst (
        .clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_in, .single_ended_zero_flag,
        .j_state_flag, .hw_res, .line_ctl, .usb_clk_en, .xcvr_low_power, .sleep_block,
        .irq
    );
    uotg_cable_model uotg_cable_model_inst (
        .cable_a, .ext_vbus, .bus_act, .line_ctl, .pins(pins_in)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function logic [31:0] stat_exp(input logic ca, input logic vb);
        return {24'h000000, ~ca, 3'h0, vb, ~ca & ~vb, 1'h0, ca & vb};
    endfunction : stat_exp
    function logic [31:0] ctl_exp(input logic [7:0] c, input logic [3:0] hw);
        return {25'h0, c[2] ? c[7:4] : hw, c[3], c[1], c[0]};
    endfunction : ctl_exp
    task stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] g, input logic [31:0] e, input int id);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t item %0d got %h exp %h", $time, id, g, e);
        end
    endtask : chk
    task idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_p, w_p, got;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge clk_sys);
            if (aw_p && s_axi_awready) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                got = 1'b1;
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask : wr
    task rd(input logic [7:0] a);
        logic ar_p, got;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ar_p = 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge clk_sys);
            if (ar_p && s_axi_arready) begin
                ar_p = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid) begin
                got = 1'b1;
                rdv = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
    endtask : rd
    task rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        rd(a);
        chk(rdv & m, e, a);
    endtask : rchk

    // ----------------------------------------
    // clock, timeout
    // ----------------------------------------
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            stop_test();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        idle(4);
        rchk(`UOTG_OFF_STAT, 32'h84, 32'hFFFFFFDF);
        for (int i = 1; i < 5; i++) begin
            rchk(8'(4 * i), 32'h0, 32'hFFFFFFFF);
        end
        rchk(8'h14, 32'h0, 32'hFFFFFFFF);
        chk({30'h0, rsp}, {30'h0, `UOTG_RESP_SLVERR}, 101);
        rchk(8'h02, 32'h0, 32'hFFFFFFFF);
        chk({31'h0, xcvr_low_power}, 32'h1, 102);
        chk({25'h0, line_ctl}, 32'h0, 103);
        $display("reset values done");
        v = xs();
        wr(`UOTG_OFF_PWRC, {v[31:8], 8'hFF});
        idle(2);
        rchk(`UOTG_OFF_PWRC, 32'h1B, 32'hFFFFFFFF);
        chk({30'h0, usb_clk_en, xcvr_low_power}, 32'h1, 104);
        wr(`UOTG_OFF_PWRC, {v[31:8], 8'h01});
        idle(2);
        chk({30'h0, usb_clk_en, xcvr_low_power}, 32'h2, 105);
        wr(`UOTG_OFF_STAT, 32'hFFFFFFFF);
        rchk(`UOTG_OFF_STAT, 32'h84, 32'hFFFFFFDF);
        $display("power and suspend done");
        for (int i = 0; i < 8; i++) begin
            v = xs();
            v[2] = i[0];
            hw_res <= v[11:8];
            wr(`UOTG_OFF_CTRL, v);
            idle(2);
            chk({25'h0, line_ctl}, ctl_exp(v[7:0], hw_res), 106);
            rchk(`UOTG_OFF_CTRL, {24'h0, v[7:0]}, 32'hFFFFFFFF);
        end
        wr(`UOTG_OFF_CTRL, 32'h0);
        s_axi_wstrb <= 4'hE;
        wr(`UOTG_OFF_CTRL, 32'hFF);
        s_axi_wstrb <= 4'hF;
        rchk(`UOTG_OFF_CTRL, 32'h0, 32'hFFFFFFFF);
        wr(8'h14, 32'hFF);
        chk({30'h0, rsp}, {30'h0, `UOTG_RESP_SLVERR}, 114);
        $display("line control done");
        for (int i = 0; i < 4; i++) begin
            cable_a <= i[1];
            ext_vbus <= i[0];
            idle(4);
            rchk(`UOTG_OFF_STAT, stat_exp(i[1], i[0]), 32'hFFFFFFDF);
        end
        wr(`UOTG_OFF_IRQF, 32'hFF);
        cable_a <= ~cable_a;
        idle(5);
        rchk(`UOTG_OFF_IRQF, 32'h80, 32'h80);
        chk({31'h0, irq}, 32'h0, 107);
        wr(`UOTG_OFF_IRQM, 32'h80);
        idle(2);
        chk({31'h0, irq}, 32'h1, 108);
        wr(`UOTG_OFF_IRQF, 32'h80);
        idle(2);
        rchk(`UOTG_OFF_IRQF, 32'h0, 32'h80);
        chk({31'h0, irq}, 32'h0, 109);
        $display("status and flags done");
        j_state_flag <= 1'b1;
        idle(1);
        rchk(`UOTG_OFF_STAT, 32'h0, 32'h20);
        idle(30);
        rchk(`UOTG_OFF_STAT, 32'h20, 32'h20);
        rchk(`UOTG_OFF_IRQF, 32'h20, 32'h20);
        single_ended_zero_flag <= 1'b1;
        idle(1);
        rchk(`UOTG_OFF_STAT, 32'h0, 32'h20);
        $display("line stable done");
        wr(`UOTG_OFF_PWRC, 32'h11);
        bus_act <= 1'b1;
        idle(4);
        chk({31'h0, sleep_block}, 32'h1, 110);
        wr(`UOTG_OFF_PWRC, 32'h01);
        idle(3);
        chk({31'h0, sleep_block}, 32'h0, 111);
        bus_act <= 1'b0;
        wr(`UOTG_OFF_PWRC, 32'h13);
        wr(`UOTG_OFF_IRQF, 32'h10);
        idle(2);
        bus_act <= 1'b1;
        idle(4);
        bus_act <= 1'b0;
        rchk(`UOTG_OFF_PWRC, 32'h80, 32'h80);
        rchk(`UOTG_OFF_IRQF, 32'h0, 32'h10);
        chk({31'h0, sleep_block}, 32'h1, 112);
        wr(`UOTG_OFF_PWRC, 32'h01);
        idle(3);
        rchk(`UOTG_OFF_IRQF, 32'h10, 32'h10);
        rchk(`UOTG_OFF_PWRC, 32'h0, 32'h80);
        $display("sleep guard done");
        wr(`UOTG_OFF_CTRL, 32'hFF);
        wr(`UOTG_OFF_PWRC, 32'h0);
        idle(2);
        chk({25'h0, line_ctl}, 32'h0, 113);
        rchk(`UOTG_OFF_PWRC, 32'h08, 32'hFFFFFFFF);
        idle(20);
        rchk(`UOTG_OFF_PWRC, 32'h0, 32'hFFFFFFFF);
        $display("disable done");
        stop_test();
    end
endmodule : tb_top
